//--- rtl/bridge_error_log_page_map.sv
// vector reply, failure logs and page map translation of the bridge
`timescale 1ns/1ps
// How it works
// (R01) unsolicited or failed identify returns programmed vector
// (R02) disable bit set gives read error instead
// (R03) software loads vector, mirrors it in companion
// (R04) vector bits 15:2 writable, others read zero
// (R05) command log freezes only on commander failure
// (R06) reload each command cycle, hold until cleared
// (R07) command field takes data 63:60, 27:26 zero
// (R08) bits 25:16 take data bits 57:48
// (R09) bits 15:0 take data bits 47:32
// (R10) error address captured on first listed error
// (R11) frozen until cleared, next error then overwrites
// (R12) length field takes internal data bits 31:30
// (R13) address field takes internal data bits 29:0
// (R14) 64K map entries at 0x200 to 0x401fc
// (R15) valid bit 31 judges entry during translation
// (R16) bit 30 is plain storage
// (R17) software loads frame for every queued page
// (R18) 512-byte pages: frame 29:0 with address 8:0
// (R19) 4K pages: frame 26:0 with address 11:0
// (R20) 8K pages: frame 25:0 with address 12:0
// (R21) translated address bit 39 always zero
// (R22) disable bit clear returns vector by default
// (R23) invalid entry raises error and logs address
module bridge_error_log_page_map #(
    parameter int CLEAR_COUNT = bridge_pkg::MAP_ENTRIES
) (
    input  wire logic        core_clk,
    input  wire logic        rst,
    input  wire logic        reg_req,
    input  wire logic        reg_we,
    input  wire logic [18:0] reg_addr,
    input  wire logic [31:0] reg_wdata,
    output logic             reg_ack,
    output logic      [31:0] reg_rdata,
    input  wire logic        vector_reply_disable,
    input  wire logic        ident_req,
    output logic             ident_vector_valid,
    output logic             read_error_response,
    output logic      [15:0] ident_vector,
    input  wire logic        ca_valid,
    input  wire logic [31:0] ca_data,
    input  wire logic [5:0]  commander_error_pending,
    input  wire logic [8:0]  internal_bus_error_set,
    input  wire logic [31:0] internal_bus_fail_data,
    input  wire logic [8:0]  internal_bus_error_pending,
    input  wire logic        xlat_req,
    output logic             xlat_ready,
    input  wire logic [1:0]  xlat_page_size,
    input  wire logic [29:0] xlat_bus_addr,
    input  wire logic [1:0]  xlat_len,
    output logic             xlat_done,
    output logic      [39:0] xlat_sys_addr,
    output logic             invalid_pfn_error
);
    typedef enum logic [1:0] {st_clear, st_idle, st_reg_rd, st_xlat} state_t;

    typedef struct packed {
        state_t      state;
        logic [15:0] clear_idx;
        logic [13:0] vector;
        logic        reg_ack;
        logic [31:0] reg_rdata;
        logic        ident_vec_valid;
        logic        ident_rer;
        logic [29:0] xlat_addr;
        logic [1:0]  xlat_size;
        logic [1:0]  xlat_len;
        logic        xlat_done;
        logic [39:0] sys_addr;
        logic        invalid;
    } bridge_state_t;

    localparam logic [15:0] CLEAR_LAST = 16'(CLEAR_COUNT - 1);

    bridge_state_t cur_reg;
    bridge_state_t cur_next;

    logic        ram_we;
    logic [15:0] ram_addr;
    logic [31:0] ram_wdata;
    logic [31:0] ram_rdata;
    logic [31:0] ext_log;
    logic [31:0] err_addr_log;
    logic [18:0] map_off;
    logic        map_hit;
    logic [15:0] map_idx;
    logic [15:0] page_idx;
    logic        ext_load;
    logic        err_load;
    logic [31:0] ext_din;
    logic [31:0] err_din;

    // register offset decode
    assign map_off = reg_addr - bridge_pkg::MAP_FIRST_OFS;
    assign map_hit = (reg_addr >= bridge_pkg::MAP_FIRST_OFS) &&
                     (reg_addr <= bridge_pkg::MAP_LAST_OFS) &&
                     (reg_addr[1:0] == 2'h0); // R14
    assign map_idx = map_off[17:2];

    // page number picked by page size
    always_comb begin
        case (xlat_page_size)
            bridge_pkg::PAGE_4K: page_idx = xlat_bus_addr[27:12];
            bridge_pkg::PAGE_8K: page_idx = xlat_bus_addr[28:13];
            default:             page_idx = xlat_bus_addr[24:9];
        endcase
    end

    // next state of the whole block
    always_comb begin
        cur_next = cur_reg;
        cur_next.reg_ack = 1'b0;
        cur_next.ident_vec_valid = 1'b0;
        cur_next.ident_rer = 1'b0;
        cur_next.xlat_done = 1'b0;
        cur_next.invalid = 1'b0;
        ram_we = 1'b0;
        ram_addr = cur_reg.clear_idx;
        ram_wdata = bridge_pkg::MAP_ENTRY_RST;
        // identify answer, vector unless disabled
        if (ident_req) begin
            if (vector_reply_disable) begin
                cur_next.ident_rer = 1'b1; // R02
            end else begin
                cur_next.ident_vec_valid = 1'b1; // R01 R22
            end
        end
        case (cur_reg.state)
            st_clear: begin
                ram_we = 1'b1;
                cur_next.clear_idx = cur_reg.clear_idx + 16'h0001;
                if (cur_reg.clear_idx == CLEAR_LAST) begin
                    cur_next.state = st_idle;
                end
            end
            st_idle: begin
                // a request still held in its ack cycle is not retaken
                if (reg_req && !cur_reg.reg_ack && map_hit) begin
                    ram_addr = map_idx; // R14
                    if (reg_we) begin
                        ram_we = 1'b1;
                        ram_wdata = reg_wdata; // R16
                        cur_next.reg_ack = 1'b1;
                    end else begin
                        cur_next.state = st_reg_rd;
                    end
                end else if (reg_req && !cur_reg.reg_ack) begin
                    cur_next.reg_ack = 1'b1;
                    cur_next.reg_rdata = 32'h0000_0000;
                    if (reg_we &&
                        reg_addr == bridge_pkg::RETURN_VECTOR_OFS) begin
                        cur_next.vector = reg_wdata[bridge_pkg::VEC_MSB:
                                                    bridge_pkg::VEC_LSB];
                    end
                    if (!reg_we) begin
                        case (reg_addr)
                            bridge_pkg::RETURN_VECTOR_OFS:
                                cur_next.reg_rdata =
                                    {16'h0000, cur_reg.vector, 2'h0}; // R04
                            bridge_pkg::FAILED_CMD_EXT_OFS:
                                cur_next.reg_rdata = ext_log;
                            bridge_pkg::EXP_ERR_ADDR_OFS:
                                cur_next.reg_rdata = err_addr_log;
                            default:
                                cur_next.reg_rdata = 32'h0000_0000;
                        endcase
                    end
                end else if (xlat_req && !reg_req) begin
                    ram_addr = page_idx;
                    cur_next.xlat_addr = xlat_bus_addr;
                    cur_next.xlat_size = xlat_page_size;
                    cur_next.xlat_len = xlat_len;
                    cur_next.state = st_xlat;
                end
            end
            st_reg_rd: begin
                cur_next.reg_rdata = ram_rdata;
                cur_next.reg_ack = 1'b1;
                cur_next.state = st_idle;
            end
            st_xlat: begin
                // frame number joined with page offset, bit 39 low
                case (cur_reg.xlat_size)
                    bridge_pkg::PAGE_4K:
                        cur_next.sys_addr = {1'b0, ram_rdata[26:0],
                                             cur_reg.xlat_addr[11:0]}; // R19
                    bridge_pkg::PAGE_8K:
                        cur_next.sys_addr = {1'b0, ram_rdata[25:0],
                                             cur_reg.xlat_addr[12:0]}; // R20
                    default:
                        cur_next.sys_addr = {1'b0, ram_rdata[29:0],
                                             cur_reg.xlat_addr[8:0]}; // R18 R21
                endcase
                cur_next.xlat_done = 1'b1;
                cur_next.invalid =
                    !ram_rdata[bridge_pkg::MAP_VALID_BIT]; // R15 R23
                cur_next.state = st_idle;
            end
            default: begin
                cur_next.state = st_idle;
            end
        endcase
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            cur_reg <= '0;
            cur_reg.state <= st_clear;
            cur_reg.vector <= bridge_pkg::RETURN_VECTOR_RST; // R04
        end else begin
            cur_reg <= cur_next;
        end
    end

    // commander log: reload each command cycle unless an error pends
    assign ext_load = ca_valid; // R06
    assign ext_din = {ca_data[31:28], 2'h0, ca_data[25:16],
                      ca_data[15:0]}; // R07 R08 R09

    error_log_capture u_ext_log (
        .core_clk (core_clk),
        .rst      (rst),
        .load     (ext_load),
        .freeze   (|commander_error_pending), // R05
        .din      (ext_din),
        .value    (ext_log)
    );

    // internal-bus log: first error only, outside set beats own fault
    assign err_load = (|internal_bus_error_set) || cur_reg.invalid; // R10 R23
    assign err_din  = (|internal_bus_error_set) ? internal_bus_fail_data :
                      {cur_reg.xlat_len, cur_reg.xlat_addr}; // R12 R13

    error_log_capture u_err_log (
        .core_clk (core_clk),
        .rst      (rst),
        .load     (err_load),
        .freeze   (|internal_bus_error_pending), // R11
        .din      (err_din),
        .value    (err_addr_log)
    );

    page_map_ram u_map (
        .core_clk (core_clk),
        .we       (ram_we),
        .addr     (ram_addr),
        .wdata    (ram_wdata),
        .rdata    (ram_rdata)
    );

    // outputs
    assign reg_ack             = cur_reg.reg_ack;
    assign reg_rdata           = cur_reg.reg_rdata;
    assign ident_vector_valid  = cur_reg.ident_vec_valid;
    assign read_error_response = cur_reg.ident_rer;
    assign ident_vector        = {cur_reg.vector, 2'h0};
    assign xlat_ready          = (cur_reg.state == st_idle) && !reg_req;
    assign xlat_done           = cur_reg.xlat_done;
    assign xlat_sys_addr       = cur_reg.sys_addr;
    assign invalid_pfn_error   = cur_reg.invalid;

    // checks
    property p_ident_vector;
        @(posedge core_clk) disable iff (rst)
        ident_req && !vector_reply_disable |=>
            ident_vector_valid && !read_error_response &&
            ident_vector == {$past(cur_reg.vector), 2'h0};
    endproperty
    a_ident_vector: assert property (p_ident_vector) // R01
        else $error("identify did not return the vector");

    property p_ident_rer;
        @(posedge core_clk) disable iff (rst)
        ident_req && vector_reply_disable |=>
            read_error_response && !ident_vector_valid;
    endproperty
    a_ident_rer: assert property (p_ident_rer) // R02
        else $error("disabled identify gave no read error");

    property p_vector_zero;
        @(posedge core_clk) disable iff (rst)
        reg_req && !reg_we && cur_reg.state == st_idle && !cur_reg.reg_ack &&
        reg_addr == bridge_pkg::RETURN_VECTOR_OFS |=>
            reg_ack && reg_rdata[31:16] == 16'h0000 &&
            reg_rdata[1:0] == 2'h0;
    endproperty
    a_vector_zero: assert property (p_vector_zero) // R04
        else $error("vector register reserved bits not zero");

    property p_ext_load;
        @(posedge core_clk) disable iff (rst)
        ca_valid && !(|commander_error_pending) |=>
            ext_log == {$past(ca_data[31:28]), 2'h0,
                        $past(ca_data[25:0])};
    endproperty
    a_ext_load: assert property (p_ext_load) // R07
        else $error("command log missed a command cycle");

    property p_ext_freeze;
        @(posedge core_clk) disable iff (rst)
        (|commander_error_pending) |=> $stable(ext_log);
    endproperty
    a_ext_freeze: assert property (p_ext_freeze) // R06
        else $error("command log changed while frozen");

    property p_err_capture;
        @(posedge core_clk) disable iff (rst)
        (|internal_bus_error_set) && !(|internal_bus_error_pending) |=>
            err_addr_log == $past(internal_bus_fail_data);
    endproperty
    a_err_capture: assert property (p_err_capture) // R10
        else $error("error address not captured");

    property p_err_freeze;
        @(posedge core_clk) disable iff (rst)
        (|internal_bus_error_pending) |=> $stable(err_addr_log);
    endproperty
    a_err_freeze: assert property (p_err_freeze) // R11
        else $error("error address changed while frozen");

    property p_xlat_valid;
        @(posedge core_clk) disable iff (rst)
        cur_reg.state == st_xlat |=> xlat_done && xlat_sys_addr[39] == 1'b0
            && invalid_pfn_error == !$past(ram_rdata[31]);
    endproperty
    a_xlat_valid: assert property (p_xlat_valid) // R15
        else $error("translation validity or bit 39 wrong");

    property p_xlat_512;
        @(posedge core_clk) disable iff (rst)
        cur_reg.state == st_xlat && cur_reg.xlat_size == bridge_pkg::PAGE_512
        |=> xlat_sys_addr[38:9] == $past(ram_rdata[29:0]);
    endproperty
    a_xlat_512: assert property (p_xlat_512) // R18
        else $error("512-byte frame join wrong");

    c_ident_vector: cover property (@(posedge core_clk) ident_vector_valid);
    c_ident_rer: cover property (@(posedge core_clk) read_error_response);
    c_invalid: cover property (@(posedge core_clk) invalid_pfn_error);
    c_ext_freeze: cover property (@(posedge core_clk)
        ca_valid && (|commander_error_pending));
endmodule // bridge_error_log_page_map

//--- rtl/bridge_pkg.sv
// constants shared by the error log and page map bridge block
package bridge_pkg;
    // register byte offsets inside the node space
    localparam logic [18:0] RETURN_VECTOR_OFS = 19'h00028;
    localparam logic [18:0] FAILED_CMD_EXT_OFS = 19'h0002c;
    localparam logic [18:0] EXP_ERR_ADDR_OFS  = 19'h00030;
    localparam logic [18:0] MAP_FIRST_OFS     = 19'h00200;
    localparam logic [18:0] MAP_LAST_OFS      = 19'h401fc;
    // field positions
    localparam int VEC_MSB       = 15;
    localparam int VEC_LSB       = 2;
    localparam int MAP_VALID_BIT = 31;
    localparam int MAP_SPARE_BIT = 30;
    // reset values
    localparam logic [13:0] RETURN_VECTOR_RST = 14'h0000;
    localparam logic [31:0] LOG_RST           = 32'h0000_0000;
    localparam logic [31:0] MAP_ENTRY_RST     = 32'h0000_0000;
    // number of page map entries
    localparam int MAP_ENTRIES = 65536;
    // page size select codes
    localparam logic [1:0] PAGE_512 = 2'h0;
    localparam logic [1:0] PAGE_4K  = 2'h1;
    localparam logic [1:0] PAGE_8K  = 2'h2;
endpackage

//--- rtl/error_log_capture.sv
// capture register that loads until frozen by a pending error
`timescale 1ns/1ps
module error_log_capture (
    input  wire logic        core_clk,
    input  wire logic        rst,
    input  wire logic        load,
    input  wire logic        freeze,
    input  wire logic [31:0] din,
    output logic      [31:0] value
);
    typedef struct packed {
        logic [31:0] value;
    } log_state_t;

    log_state_t state_reg;
    log_state_t state_next;

    // reload on each event, hold while an error stays pending
    always_comb begin
        state_next = state_reg;
        if (load && !freeze) begin
            state_next.value = din;
        end
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            state_reg.value <= bridge_pkg::LOG_RST;
        end else begin
            state_reg <= state_next;
        end
    end

    assign value = state_reg.value;
endmodule // error_log_capture

//--- rtl/page_map_ram.sv
// single-port page map storage with registered read data
`timescale 1ns/1ps
module page_map_ram (
    input  wire logic        core_clk,
    input  wire logic        we,
    input  wire logic [15:0] addr,
    input  wire logic [31:0] wdata,
    output logic      [31:0] rdata
);
    logic [31:0] mem [0:bridge_pkg::MAP_ENTRIES-1];
    logic [31:0] rdata_reg;

    // write first slot, read old contents one edge later
    always_ff @(posedge core_clk) begin
        if (we) begin
            mem[addr] <= wdata;
        end
        rdata_reg <= mem[addr];
    end

    assign rdata = rdata_reg;
endmodule // page_map_ram

//--- test/error_status_model.sv
// error status model standing in for the summary register outside
`timescale 1ns/1ps
module error_status_model (
    input  wire logic       core_clk,
    input  wire logic       rst,
    input  wire logic [5:0] cmd_fail,
    input  wire logic [8:0] internal_bus_error_set,
    input  wire logic       invalid_pfn_error,
    input  wire logic       status_clear,
    output logic      [5:0] commander_error_pending,
    output logic      [8:0] internal_bus_error_pending
);
    // status bits set by failures, held until software clears them
    always_ff @(posedge core_clk) begin
        if (rst || status_clear) begin
            commander_error_pending <= 6'h00;
            internal_bus_error_pending      <= 9'h000;
        end else begin
            commander_error_pending <= commander_error_pending | cmd_fail;
            internal_bus_error_pending <= internal_bus_error_pending | internal_bus_error_set
                                  | {invalid_pfn_error, 8'h00};
        end
    end
endmodule // error_status_model

//--- test/tb_top.sv
// self-checking bench for the error log and page map bridge block
`timescale 1ns/1ps
module tb_top;
    logic        core_clk = 1'b0, rst = 1'b1, reg_req = 1'b0;
    logic        reg_we = 1'b0, vector_reply_disable = 1'b0;
    logic        ident_req = 1'b0, ca_valid = 1'b0, xlat_req = 1'b0;
    logic        status_clear = 1'b0;
    logic        reg_ack, ident_vector_valid, read_error_response;
    logic        xlat_ready, xlat_done, invalid_pfn_error;
    logic [1:0]  xlat_page_size = 2'h0, xlat_len = 2'h0;
    logic [5:0]  cmd_fail = 6'h00, commander_error_pending;
    logic [8:0]  internal_bus_error_set = 9'h000, internal_bus_error_pending;
    logic [15:0] ident_vector;
    logic [18:0] reg_addr = 19'h00000;
    logic [18:0] ro [4] = '{19'h0002c, 19'h00030, 19'h00034, 19'h40200};
    logic [29:0] xlat_bus_addr = 30'h0;
    logic [29:0] xa [4] = '{30'h2000_0ba5, 30'h3000_5abc, 30'h2000_babc,
                            30'h2000_0b5a};
    logic [31:0] reg_wdata = 32'h0, ca_data = 32'h0, internal_bus_fail_data = 32'h0;
    logic [31:0] reg_rdata, rd, d;
    logic [39:0] xlat_sys_addr, e;
    int          fails = 0, n_compared = 0;

    bridge_error_log_page_map #(.CLEAR_COUNT(16))
        u_bridge_error_log_page_map (
        .core_clk, .rst, .reg_req, .reg_we, .reg_addr, .reg_wdata, .reg_ack,
        .reg_rdata, .vector_reply_disable, .ident_req, .ident_vector_valid,
        .read_error_response, .ident_vector, .ca_valid, .ca_data,
        .commander_error_pending, .internal_bus_error_set, .internal_bus_fail_data,
        .internal_bus_error_pending, .xlat_req, .xlat_ready, .xlat_page_size,
        .xlat_bus_addr, .xlat_len, .xlat_done, .xlat_sys_addr,
        .invalid_pfn_error
    );
    error_status_model u_error_status_model (
        .core_clk, .rst, .cmd_fail, .internal_bus_error_set, .invalid_pfn_error,
        .status_clear, .commander_error_pending, .internal_bus_error_pending
    );

    // clock, 100 ns period
    initial begin
        forever #50 core_clk = ~core_clk;
    end

    task automatic chk_val(input string w, input logic [39:0] x, g);
        n_compared++;
        if (g !== x) begin
            fails++;
            $display("CHECK FAILED %s expected %h seen %h", w, x, g);
        end
    endtask
    task automatic chk_bit(input string w, input logic x, g);
        n_compared++;
        if (g !== x) begin
            fails++;
            $display("CHECK FAILED %s expected %b seen %b", w, x, g);
        end
    endtask
    task automatic done(input string t);
        $display("test %s finished", t);
    endtask
    // one register access: request held until the answer is seen
    task automatic reg_access(input logic w, input logic [18:0] a,
                              input logic [31:0] v);
        int n;
        n = 0;
        while (xlat_ready !== 1'b1 && n < 200) begin
            @(posedge core_clk);
            n++;
        end
        reg_req <= 1'b1;
        reg_we <= w;
        reg_addr <= a;
        reg_wdata <= v;
        n = 0;
        do begin
            @(posedge core_clk);
            n++;
        end while (reg_ack !== 1'b1 && n < 8);
        rd = reg_rdata;
        reg_req <= 1'b0;
        chk_bit("reg_ack", 1'b1, reg_ack);
    endtask
    task automatic rd_chk(input string w, input logic [18:0] a,
                          input logic [31:0] x);
        reg_access(1'b0, a, 32'h0);
        chk_val(w, {8'h00, x}, {8'h00, rd});
    endtask
    task automatic ident(input logic dis);
        vector_reply_disable <= dis;
        @(posedge core_clk);
        ident_req <= 1'b1;
        @(posedge core_clk);
        ident_req <= 1'b0;
        @(posedge core_clk);
    endtask
    task automatic ca(input logic [31:0] v);
        ca_valid <= 1'b1;
        ca_data <= v;
        @(posedge core_clk);
        ca_valid <= 1'b0;
        @(posedge core_clk);
    endtask
    task automatic ev(input int k, input logic [31:0] v);
        internal_bus_error_set <= 9'h001 << k;
        internal_bus_fail_data <= v;
        @(posedge core_clk);
        internal_bus_error_set <= 9'h000;
        @(posedge core_clk);
    endtask
    task automatic clear();
        status_clear <= 1'b1;
        @(posedge core_clk);
        status_clear <= 1'b0;
        @(posedge core_clk);
    endtask
    // translation request, waits for the done pulse
    task automatic xlat(input int s, input logic [1:0] len);
        int n;
        n = 0;
        while (xlat_ready !== 1'b1 && n < 200) begin
            @(posedge core_clk);
            n++;
        end
        xlat_req <= 1'b1;
        xlat_page_size <= 2'(s);
        xlat_bus_addr <= (s < 4) ? xa[s] : 30'h1000_0c33;
        xlat_len <= len;
        @(posedge core_clk);
        xlat_req <= 1'b0;
        n = 0;
        do begin
            @(posedge core_clk);
            n++;
        end while (xlat_done !== 1'b1 && n < 8);
        chk_bit("xlat_done", 1'b1, xlat_done);
    endtask
    function automatic logic [39:0] xl(input int s, input logic [29:0] a);
        logic [29:0] f;
        f = 30'h3a5c_6e1d;
        if (s == 1) xl = {1'b0, f[26:0], a[11:0]};
        else if (s == 2) xl = {1'b0, f[25:0], a[12:0]};
        else xl = {1'b0, f[29:0], a[8:0]};
    endfunction
    task automatic end_sim();
        $display("compared %0d mismatches %0d", n_compared, fails);
        if (fails == 0 && n_compared > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    // watchdog against a hung handshake
    initial begin
        repeat (5000) @(posedge core_clk);
        fails++;
        $display("CHECK FAILED watchdog expected end seen timeout");
        end_sim();
    end

    // main test sequence
    initial begin
        repeat (16) @(posedge core_clk);
        rst <= 1'b0;
        rd_chk("vector", bridge_pkg::RETURN_VECTOR_OFS, 32'h0);
        rd_chk("map0", bridge_pkg::MAP_FIRST_OFS, 32'h0);
        foreach (ro[i]) begin
            reg_access(1'b1, ro[i], 32'hffff_ffff);
            rd_chk("read only", ro[i], 32'h0);
        end
        done("reset");
        reg_access(1'b1, bridge_pkg::RETURN_VECTOR_OFS, 32'hffff_ffff);
        rd_chk("vector", bridge_pkg::RETURN_VECTOR_OFS, 32'h0000_fffc);
        reg_access(1'b1, bridge_pkg::RETURN_VECTOR_OFS, 32'h1234_5679);
        rd_chk("vector", bridge_pkg::RETURN_VECTOR_OFS, 32'h0000_5678);
        chk_val("ident vector", 40'h5678, {24'h0, ident_vector});
        ident(1'b0);
        chk_bit("vector reply", 1'b1, ident_vector_valid);
        chk_bit("error reply", 1'b0, read_error_response);
        ident(1'b1);
        chk_bit("vector reply", 1'b0, ident_vector_valid);
        chk_bit("error reply", 1'b1, read_error_response);
        done("vector");
        for (int k = 0; k < 6; k++) begin
            d = 32'hfedc_ba98 ^ 32'(k);
            ca(d);
            rd_chk("cmd log", 19'h0002c, d & 32'hf3ff_ffff);
            cmd_fail <= 6'h01 << k;
            @(posedge core_clk);
            cmd_fail <= 6'h00;
            @(posedge core_clk);
            ca(~d);
            rd_chk("frozen cmd log", 19'h0002c, d & 32'hf3ff_ffff);
            clear();
            ca(~d);
            rd_chk("cmd log", 19'h0002c, ~d & 32'hf3ff_ffff);
        end
        done("command log");
        for (int k = 0; k < 9; k++) begin
            d = 32'h9abc_def0 + 32'(k);
            ev(k, d);
            ev(k, ~d);
            rd_chk("bus log", 19'h00030, d);
            clear();
            ev(k, ~d);
            rd_chk("bus log", 19'h00030, ~d);
            clear();
        end
        done("bus log");
        reg_access(1'b1, 19'h00214, 32'hfa5c_6e1d);
        rd_chk("map entry", 19'h00214, 32'hfa5c_6e1d);
        reg_access(1'b1, bridge_pkg::MAP_LAST_OFS, 32'h4000_0001);
        rd_chk("last entry", bridge_pkg::MAP_LAST_OFS, 32'h4000_0001);
        for (int s = 0; s < 4; s++) begin
            xlat(s, 2'h1);
            e = xl(s, xa[s]);
            chk_val("sys addr", e, xlat_sys_addr);
            chk_bit("invalid", 1'b0, invalid_pfn_error);
        end
        rd_chk("cleared entry", 19'h00218, 32'h0);
        xlat(4, 2'h2);
        chk_bit("invalid", 1'b1, invalid_pfn_error);
        rd_chk("bus log", 19'h00030, 32'h9000_0c33);
        done("page map");
        end_sim();
    end
endmodule // tb_top
